// ===== src/uftr_core.sv
`timescale 1ns/1ps
module uftr_core (
    input  wire logic                      ref_clk_i,
    input  wire logic                      reset_n_i,
    input  wire uftr_pkg::uftr_bus_t       bus_i,
    input  wire uftr_pkg::uftr_chan_t [1:0] chan_i,
    output logic [7:0]                     rdata_o,
    output logic                           rd_valid_o,
    output logic                           alt_sel_o,
    output logic [1:0]                     rts_n_o,
    output logic [7:0]                     fifo_ready_o
);

    // nibble times four, as a byte count
    function automatic logic [uftr_pkg::CNT_W-1:0] scale_lvl(
        input logic [3:0] nib
    );
        scale_lvl = {1'b0, nib, 2'b00};
    endfunction : scale_lvl

    // zero nibble hands the level back to fifo control
    function automatic logic [uftr_pkg::CNT_W-1:0] eff_lvl(
        input logic [3:0]                 nib,
        input logic [uftr_pkg::CNT_W-1:0] ctl_lvl
    );
        eff_lvl = (nib == 4'h0) ? ctl_lvl : scale_lvl(nib);
    endfunction : eff_lvl

    uftr_pkg::uftr_state_t st;
    uftr_pkg::uftr_state_t st_next;
    logic [1:0]            sel;
    logic [1:0]            win;
    logic                  ch;
    logic                  acc;

    // which channels the host addresses, and their enable window
    always_comb
    begin
        sel = {~bus_i.cs_b_n, ~bus_i.cs_a_n};
        ch  = bus_i.cs_a_n;                          // channel A wins reads
        acc = (sel != 2'b00) && (bus_i.wr || bus_i.rd);
        for (int c = 0; c < 2; c++)
        begin
            win[c] = chan_i[c].feat[uftr_pkg::FEAT_WEN_BIT] &&
                     chan_i[c].modem[uftr_pkg::MODEM_WIN_BIT];
        end
    end

    // next state: status, request outputs, register access
    always_comb
    begin
        st_next          = st;
        st_next.rd_valid = 1'b0;
        st_next.alt_hit  = 1'b0;
        st_next.ready    = 8'h00;
        for (int c = 0; c < 2; c++)
        begin
            // live compare, no latching of old levels
            st_next.ready[uftr_pkg::RDY_TX_POS + c] =
                chan_i[c].tx_free >=
                eff_lvl(st.trig[c][3:0], chan_i[c].fifo_tx_lvl);
            st_next.ready[uftr_pkg::RDY_RX_POS + c] =
                (chan_i[c].rx_count >
                 eff_lvl(st.trig[c][7:4], chan_i[c].fifo_rx_lvl)) ||
                chan_i[c].rx_timeout;
            // halt checked first: inconsistent levels are not repaired
            if (chan_i[c].feat[uftr_pkg::FEAT_FLOW_BIT])
            begin
                if (chan_i[c].rx_count >= scale_lvl(st.flow[c][3:0]))
                    st_next.rts_n[c] = 1'b1;
                else if (chan_i[c].rx_count <= scale_lvl(st.flow[c][7:4]))
                    st_next.rts_n[c] = 1'b0;
            end
            else
            begin
                st_next.rts_n[c] =
                    ~chan_i[c].modem[uftr_pkg::MODEM_RTS_BIT];
            end
        end
        if (acc)
        begin
            if (bus_i.addr == uftr_pkg::ADDR_ALT_FN &&
                chan_i[ch].line[7:5] == uftr_pkg::LINE_ALT_KEY)
            begin
                st_next.alt_hit = 1'b1;
            end
            // read data only moves on an answered read
            else if (win[ch] && bus_i.addr == uftr_pkg::ADDR_FLOW)
            begin
                if (bus_i.rd)
                    st_next.rdata = st.flow[ch];
                st_next.rd_valid = bus_i.rd;
            end
            else if (win[ch] && bus_i.addr == uftr_pkg::ADDR_TRIG)
            begin
                if (bus_i.rd)
                    st_next.rdata = st.trig[ch];
                st_next.rd_valid = bus_i.rd;
            end
            else if (bus_i.addr == uftr_pkg::ADDR_RDY && bus_i.rd &&
                     chan_i[ch].modem[uftr_pkg::MODEM_RDY_BIT] &&
                     !chan_i[ch].modem[uftr_pkg::MODEM_LOOP_BIT])
            begin
                st_next.rdata    = st_next.ready;
                st_next.rd_valid = 1'b1;
            end
            // writes: every selected channel with its own window open
            for (int c = 0; c < 2; c++)
            begin
                if (bus_i.wr && sel[c] && win[c])
                begin
                    if (bus_i.addr == uftr_pkg::ADDR_FLOW)
                        st_next.flow[c] = bus_i.wdata;
                    else if (bus_i.addr == uftr_pkg::ADDR_TRIG)
                        st_next.trig[c] = bus_i.wdata;
                end
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st.flow     <= {uftr_pkg::FLOW_RST, uftr_pkg::FLOW_RST};
            st.trig     <= {uftr_pkg::TRIG_RST, uftr_pkg::TRIG_RST};
            st.rdata    <= uftr_pkg::RDATA_RST;
            st.rd_valid <= 1'b0;
            st.alt_hit  <= 1'b0;
            st.rts_n    <= uftr_pkg::RTS_N_RST;
            st.ready    <= uftr_pkg::READY_RST;
        end
        else
        begin
            st <= st_next;
        end
    end

    // outputs straight from the state flops
    assign rdata_o      = st.rdata;
    assign rd_valid_o   = st.rd_valid;
    assign alt_sel_o    = st.alt_hit;
    assign rts_n_o      = st.rts_n;
    assign fifo_ready_o = st.ready;

    // checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_flow_wr_a;
        bus_i.wr && !bus_i.cs_a_n && bus_i.addr == uftr_pkg::ADDR_FLOW;
    endsequence

    sequence s_trig_wr_b;
        bus_i.wr && !bus_i.cs_b_n && bus_i.addr == uftr_pkg::ADDR_TRIG;
    endsequence

    sequence s_rdy_rd_a;
        bus_i.rd && !bus_i.cs_a_n && bus_i.addr == uftr_pkg::ADDR_RDY &&
        chan_i[0].modem[uftr_pkg::MODEM_RDY_BIT] &&
        !chan_i[0].modem[uftr_pkg::MODEM_LOOP_BIT] && !win[0];
    endsequence

    a_flow_write_take: assert property (
        s_flow_wr_a ##0 win[0] |=> st.flow[0] == $past(bus_i.wdata))
        else $error("flow level write lost");

    a_flow_write_gate: assert property (
        s_flow_wr_a ##0 !win[0] |=> $stable(st.flow[0]))
        else $error("flow level written while closed");

    a_trig_write_gate: assert property (
        s_trig_wr_b ##0 !win[1] |=> $stable(st.trig[1]))
        else $error("trigger level written while closed");

    a_tx_ctl_fallback: assert property (
        st.trig[0][3:0] == 4'h0 &&
        chan_i[0].tx_free < chan_i[0].fifo_tx_lvl |=> !fifo_ready_o[0])
        else $error("tx ready ignores fifo control level");

    a_tx_level_b: assert property (
        st.trig[1][3:0] != 4'h0 && !(bus_i.wr && !bus_i.cs_b_n) &&
        chan_i[1].tx_free >= {1'b0, st.trig[1][3:0], 2'b00}
        |=> fifo_ready_o[1])
        else $error("tx ready B missing");

    a_rx_timeout_b: assert property (
        chan_i[1].rx_timeout |=> fifo_ready_o[5])
        else $error("rx timeout not shown");

    a_rx_level_a: assert property (
        st.trig[0][7:4] != 4'h0 && !chan_i[0].rx_timeout &&
        chan_i[0].rx_count <= {1'b0, st.trig[0][7:4], 2'b00}
        |=> !fifo_ready_o[4])
        else $error("rx ready A set at or below trigger");

    a_unused_zero: assert property (
        fifo_ready_o[3:2] == 2'b00 && fifo_ready_o[7:6] == 2'b00)
        else $error("unused ready bits set");

    a_rdy_read_ret: assert property (
        s_rdy_rd_a |=> rd_valid_o && rdata_o == fifo_ready_o)
        else $error("ready status read wrong");

    a_rts_halt_a: assert property (
        chan_i[0].feat[uftr_pkg::FEAT_FLOW_BIT] &&
        chan_i[0].rx_count >= {1'b0, st.flow[0][3:0], 2'b00}
        |=> rts_n_o[0])
        else $error("request not raised at halt level");

    a_rts_restore_a: assert property (
        chan_i[0].feat[uftr_pkg::FEAT_FLOW_BIT] &&
        chan_i[0].rx_count < {1'b0, st.flow[0][3:0], 2'b00} &&
        chan_i[0].rx_count <= {1'b0, st.flow[0][7:4], 2'b00}
        |=> !rts_n_o[0])
        else $error("request not dropped at restore level");

    a_alt_decode: assert property (
        acc && bus_i.addr == uftr_pkg::ADDR_ALT_FN &&
        chan_i[ch].line[7:5] != uftr_pkg::LINE_ALT_KEY |=> !alt_sel_o)
        else $error("alternate slot decoded without key");

endmodule : uftr_core

// ===== src/uftr_pkg.sv
package uftr_pkg;

    // width of fifo occupancy counts, 0..64
    localparam int          CNT_W            = 7;

    // register offsets on the 3-bit host address
    localparam logic [2:0]  ADDR_ALT_FN      = 3'h2;
    localparam logic [2:0]  ADDR_FLOW        = 3'h6;
    localparam logic [2:0]  ADDR_TRIG        = 3'h7;
    localparam logic [2:0]  ADDR_RDY         = 3'h7;

    // line_control[7:5] pattern that opens the alternate function slot
    localparam logic [2:0]  LINE_ALT_KEY     = 3'h4;

    // bit positions in the channel control registers
    localparam int          FEAT_WEN_BIT     = 4;
    localparam int          FEAT_FLOW_BIT    = 6;
    localparam int          MODEM_RTS_BIT    = 1;
    localparam int          MODEM_RDY_BIT    = 2;
    localparam int          MODEM_LOOP_BIT   = 4;
    localparam int          MODEM_WIN_BIT    = 6;

    // fifo_ready_status field positions
    localparam int          RDY_TX_POS       = 0;
    localparam int          RDY_RX_POS       = 4;

    // values after reset
    localparam logic [7:0]  FLOW_RST         = 8'h00;
    localparam logic [7:0]  TRIG_RST         = 8'h00;
    localparam logic [7:0]  RDATA_RST        = 8'h00;
    localparam logic [7:0]  READY_RST        = 8'h00;
    localparam logic [1:0]  RTS_N_RST        = 2'h3;

    // host bus cycle, sampled on ref_clk_i
    typedef struct packed {
        logic             cs_a_n;
        logic             cs_b_n;
        logic [2:0]       addr;
        logic             wr;
        logic             rd;
        logic [7:0]       wdata;
    } uftr_bus_t;

    // per-channel view of the surrounding uart
    typedef struct packed {
        logic [7:0]       feat;
        logic [7:0]       modem;
        logic [7:0]       line;
        logic [CNT_W-1:0] fifo_tx_lvl;
        logic [CNT_W-1:0] fifo_rx_lvl;
        logic [CNT_W-1:0] tx_free;
        logic [CNT_W-1:0] rx_count;
        logic             rx_timeout;
    } uftr_chan_t;

    // whole state of the block
    typedef struct packed {
        logic [1:0][7:0]  flow;
        logic [1:0][7:0]  trig;
        logic [7:0]       rdata;
        logic             rd_valid;
        logic             alt_hit;
        logic [1:0]       rts_n;
        logic [7:0]       ready;
    } uftr_state_t;

endpackage : uftr_pkg

// ===== test/uftr_host_model.sv
`timescale 1ns/1ps
module uftr_host_model (
    input  wire logic          ref_clk_i,
    input  wire logic [7:0]    rdata_i,
    input  wire logic          rd_valid_i,
    input  wire logic          alt_sel_i,
    output uftr_pkg::uftr_bus_t bus_o
);
    // idle bus: no select, no strobe
    initial bus_o = '{1'b1, 1'b1, 3'h0, 1'b0, 1'b0, 8'h00};

    // one access, launched at a falling edge and held over the taking edge;
    // the answer stands in the next cycle, so it is sampled there
    task automatic xfer(input logic [1:0] cs_n, input logic [2:0] addr,
                        input logic wr, input logic [7:0] wdata,
                        output logic vld, output logic hit,
                        output logic [7:0] rdata);
        @(negedge ref_clk_i);
        bus_o = '{cs_n[0], cs_n[1], addr, wr, ~wr, wdata};
        @(negedge ref_clk_i);
        vld = rd_valid_i;
        hit = alt_sel_i;
        rdata = rdata_i;
        // released lines show inverted values so stale data never matches
        bus_o = '{1'b1, 1'b1, ~addr, 1'b0, 1'b0, ~wdata};
    endtask : xfer
endmodule : uftr_host_model

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
    logic                       ref_clk_i;
    logic                       reset_n_i;
    uftr_pkg::uftr_bus_t        bus;
    uftr_pkg::uftr_chan_t [1:0] chan;
    logic [7:0]                 rdata;
    logic                       rd_valid;
    logic                       alt_sel;
    logic [1:0]                 rts_n;
    logic [7:0]                 ready;
    int                         failures;
    int                         num_checks;
    integer                     seed;
    logic                       vld;
    logic                       hit;
    logic [7:0]                 dat;
    logic [7:0]                 d;
    logic [1:0]                 g;
    logic [1:0][7:0]            regs;
    logic [1:0][7:0]            trig;
    logic [6:0]                 rxs [5];
    logic [4:0]                 rte;

    uftr_core uftr_core_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .bus_i(bus), .chan_i(chan), .rdata_o(rdata), .rd_valid_o(rd_valid),
        .alt_sel_o(alt_sel), .rts_n_o(rts_n), .fifo_ready_o(ready));
    uftr_host_model uftr_host_model_i (.ref_clk_i(ref_clk_i),
        .rdata_i(rdata), .rd_valid_i(rd_valid), .alt_sel_i(alt_sel),
        .bus_o(bus));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task tally_and_finish;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    task acc(input logic [1:0] cs, input logic [2:0] a, input logic wr,
             input logic [7:0] wd);
        uftr_host_model_i.xfer(cs, a, wr, wd, vld, hit, dat);
    endtask : acc

    task setw(input int c, input logic [7:0] feat, modem, line);
        @(negedge ref_clk_i);
        chan[c].feat = feat;
        chan[c].modem = modem;
        chan[c].line = line;
    endtask : setw

    // counts near multiples of four so equality with a level is frequent
    function logic [6:0] r7();
        r7 = 7'(({$random(seed)} % 16) * 4 + {$random(seed)} % 3);
    endfunction : r7

    // effective level is nibble times four, or the fifo control level
    function logic [7:0] exp_rdy(input logic [1:0][7:0] t);
        logic [7:0] r;
        logic [6:0] e;
        r = 8'h00;
        for (int c = 0; c < 2; c++)
        begin
            e = (t[c][3:0] != 4'h0) ? {1'b0, t[c][3:0], 2'b00}
                                    : chan[c].fifo_tx_lvl;
            r[c] = chan[c].tx_free >= e;
            e = (t[c][7:4] != 4'h0) ? {1'b0, t[c][7:4], 2'b00}
                                    : chan[c].fifo_rx_lvl;
            r[4+c] = (chan[c].rx_count > e) || chan[c].rx_timeout;
        end
        return r;
    endfunction : exp_rdy

    // watchdog far beyond the expected run of about 335 cycles
    initial
    begin
        #500000;
        failures++;
        tally_and_finish();
    end

    initial
    begin
        seed = 95506;
        failures = 0;
        num_checks = 0;
        chan = '0;
        regs = '0;
        reset_n_i = 1'b0;
        rxs = '{7'h00, 7'h13, 7'h14, 7'h0C, 7'h08};
        rte = 5'h0C;
        repeat (8) @(posedge ref_clk_i);
        check({rd_valid, 5'h00, rts_n}, 8'h03);
        check(ready, 8'h00);
        @(negedge ref_clk_i) reset_n_i = 1'b1;
        // writes land only with the window open; readback otherwise stale
        for (int i = 0; i < 12; i++)
        begin
            d = 8'($random(seed));
            g = 2'($random(seed));
            setw(0, {3'h0, g[0], 4'h0}, {1'b0, g[1], 6'h04}, 8'h00);
            acc(2'b10, i[0] ? uftr_pkg::ADDR_TRIG : uftr_pkg::ADDR_FLOW,
                1'b1, d);
            if (g == 2'b11)
                regs[i[0]] = d;
            setw(0, 8'h10, 8'h44, 8'h00);
            acc(2'b10, i[0] ? uftr_pkg::ADDR_TRIG : uftr_pkg::ADDR_FLOW,
                1'b0, d);
            check(dat, regs[i[0]]);
        end
        // ready status against random levels and occupancy
        for (int i = 0; i < 20; i++)
        begin
            setw(0, 8'h10, 8'h44, 8'h00);
            setw(1, 8'h10, 8'h44, 8'h00);
            trig[0] = 8'($random(seed));
            trig[1] = (i % 3 == 0) ? 8'h00 : 8'($random(seed));
            acc(2'b10, uftr_pkg::ADDR_TRIG, 1'b1, trig[0]);
            acc(2'b01, uftr_pkg::ADDR_TRIG, 1'b1, trig[1]);
            @(negedge ref_clk_i);
            for (int c = 0; c < 2; c++)
            begin
                chan[c].modem = 8'h04;
                chan[c].fifo_tx_lvl = r7();
                chan[c].fifo_rx_lvl = r7();
                chan[c].tx_free = r7();
                chan[c].rx_count = r7();
                chan[c].rx_timeout = ($random(seed) & 7) == 0;
            end
            acc(2'b00, uftr_pkg::ADDR_RDY, 1'b1, 8'hFF);
            acc(i[0] ? 2'b01 : 2'b10, uftr_pkg::ADDR_RDY, 1'b0, 8'h00);
            check({7'h00, vld}, 8'h01);
            check(dat, exp_rdy(trig));
            check(ready, exp_rdy(trig));
        end
        // loopback on, then status disabled: no answer
        for (int i = 0; i < 2; i++)
        begin
            setw(0, 8'h00, i[0] ? 8'h00 : 8'h14, 8'h00);
            acc(2'b10, uftr_pkg::ADDR_RDY, 1'b0, 8'h00);
            check({7'h00, vld}, 8'h00);
        end
        // alternate function slot opens only for line control 100
        for (int i = 0; i < 3; i++)
        begin
            d = (i == 0) ? 8'h80 : (i == 1) ? 8'h00 : 8'hA0;
            setw(0, 8'h00, 8'h00, d);
            acc(2'b10, uftr_pkg::ADDR_ALT_FN, 1'b0, 8'h00);
            check({7'h00, hit}, {7'h00, d[7:5] == 3'h4});
        end
        // levels loaded with halt above restore before flow is enabled
        setw(0, 8'h10, 8'h40, 8'h00);
        acc(2'b10, uftr_pkg::ADDR_FLOW, 1'b1, 8'h25);
        setw(0, 8'h50, 8'h40, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            @(negedge ref_clk_i) chan[0].rx_count = rxs[i];
            @(negedge ref_clk_i);
            check({7'h00, rts_n[0]}, {7'h00, rte[i]});
        end
        // inconsistent levels are used as written: halt wins
        acc(2'b10, uftr_pkg::ADDR_FLOW, 1'b1, 8'h31);
        @(negedge ref_clk_i) check({7'h00, rts_n[0]}, 8'h01);
        setw(0, 8'h10, 8'h42, 8'h00);
        @(negedge ref_clk_i) check({7'h00, rts_n[0]}, 8'h00);
        tally_and_finish();
    end
endmodule : tb
